// ### lcb_pkg.sv
// package: constants, opcodes, decode table and types for the logic/compare/bcd executor
package lcb_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // machine cycle timing
   localparam int          MC_TICKS = 8;                 // system clocks per machine cycle
   localparam int          DIV_W    = 3;
   localparam logic [2:0]  MC_LAST  = 3'(MC_TICKS - 1);

   ////////////////////////////////////////////////////////////////////////////
   // special function addresses kept inside the block, and the bit area base
   localparam logic [7:0]  ACC_ADDR = 8'hE0;             // accumulator_register
   localparam logic [7:0]  PSW_ADDR = 8'hD0;             // program_status_word
   localparam logic [3:0]  BIT_RAM_BASE = 4'h2;          // bit area bytes 20h..2Fh

   // program_status_word bit positions
   localparam int          PSW_CY  = 7;
   localparam int          PSW_AC  = 6;
   localparam int          PSW_RS1 = 4;
   localparam int          PSW_RS0 = 3;
   localparam int          PSW_OV  = 2;
   localparam int          PSW_PAR = 0;

   // bcd correction
   localparam logic [3:0]  BCD_MAX = 4'h9;
   localparam logic [3:0]  BCD_FIX = 4'h6;

   ////////////////////////////////////////////////////////////////////////////
   // opcodes
   localparam logic [7:0]  OPC_AND_A_REG  = 8'h58;       // 0101_1rrr
   localparam logic [7:0]  OPC_AND_A_IND  = 8'h56;       // 0101_011i
   localparam logic [7:0]  OPC_AND_A_DIR  = 8'h55;
   localparam logic [7:0]  OPC_AND_A_IMM  = 8'h54;
   localparam logic [7:0]  OPC_AND_D_A    = 8'h52;
   localparam logic [7:0]  OPC_AND_D_IMM  = 8'h53;
   localparam logic [7:0]  OPC_AND_C_BIT  = 8'h82;
   localparam logic [7:0]  OPC_AND_C_NBIT = 8'hB0;
   localparam logic [7:0]  OPC_CMP_A_DIR  = 8'hB5;
   localparam logic [7:0]  OPC_CMP_A_IMM  = 8'hB4;
   localparam logic [7:0]  OPC_CMP_IND    = 8'hB6;       // 1011_011i
   localparam logic [7:0]  OPC_CMP_REG    = 8'hB8;       // 1011_1rrr
   localparam logic [7:0]  OPC_CLR_A      = 8'hE4;
   localparam logic [7:0]  OPC_CLR_C      = 8'hC3;
   localparam logic [7:0]  OPC_CLR_BIT    = 8'hC2;
   localparam logic [7:0]  OPC_INV_A      = 8'hF4;
   localparam logic [7:0]  OPC_INV_C      = 8'hB3;
   localparam logic [7:0]  OPC_INV_BIT    = 8'hB2;
   localparam logic [7:0]  OPC_DEC_ADJ    = 8'hD4;

   // lengths in bytes stored as the count, cycles stored as count minus one
   localparam logic [1:0]  LEN1 = 2'h1;
   localparam logic [1:0]  LEN2 = 2'h2;
   localparam logic [1:0]  LEN3 = 2'h3;
   localparam logic        CYC1 = 1'h0;
   localparam logic        CYC2 = 1'h1;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [3:0] {
      C_NONE   = 4'h0, C_AND_A  = 4'h1, C_AND_DA = 4'h2, C_AND_DI = 4'h3,
      C_AND_C  = 4'h4, C_AND_NC = 4'h5, C_CMP    = 4'h6, C_CLR_A  = 4'h7,
      C_CLR_C  = 4'h8, C_CLR_B  = 4'h9, C_INV_A  = 4'hA, C_INV_C  = 4'hB,
      C_INV_B  = 4'hC, C_DA     = 4'hD
   } lcb_cls_t;

   typedef enum logic [2:0] {
      M_NONE = 3'h0, M_REG = 3'h1, M_IND = 3'h2, M_DIR = 3'h3, M_IMM = 3'h4, M_BIT = 3'h5
   } lcb_src_t;

   typedef enum logic [2:0] {
      S_OP = 3'b000, S_B2 = 3'b001, S_B3 = 3'b010, S_RDP = 3'b011,
      S_RDO = 3'b100, S_EXEC = 3'b101, S_WAIT = 3'b110
   } lcb_state_t;

   typedef struct packed {
      lcb_cls_t   cls;
      lcb_src_t   src;
      logic [1:0] len;
      logic       cyc;
   } lcb_dec_t;

   ////////////////////////////////////////////////////////////////////////////
   // opcode decode: class, source mode, length, cycles
   function automatic lcb_dec_t lcb_decode(input logic [7:0] op);
      lcb_dec_t d;
      d = '{cls: C_NONE, src: M_NONE, len: LEN1, cyc: CYC1};
      if (op[7:3] == OPC_AND_A_REG[7:3])      d = '{C_AND_A,  M_REG,  LEN1, CYC1};
      else if (op[7:1] == OPC_AND_A_IND[7:1]) d = '{C_AND_A,  M_IND,  LEN1, CYC1};
      else if (op == OPC_AND_A_DIR)           d = '{C_AND_A,  M_DIR,  LEN2, CYC1};
      else if (op == OPC_AND_A_IMM)           d = '{C_AND_A,  M_IMM,  LEN2, CYC1};
      else if (op == OPC_AND_D_A)             d = '{C_AND_DA, M_DIR,  LEN2, CYC1};
      else if (op == OPC_AND_D_IMM)           d = '{C_AND_DI, M_DIR,  LEN3, CYC2};
      else if (op == OPC_AND_C_BIT)           d = '{C_AND_C,  M_BIT,  LEN2, CYC2};
      else if (op == OPC_AND_C_NBIT)          d = '{C_AND_NC, M_BIT,  LEN2, CYC2};
      else if (op == OPC_CMP_A_DIR)           d = '{C_CMP,    M_DIR,  LEN3, CYC2};
      else if (op == OPC_CMP_A_IMM)           d = '{C_CMP,    M_IMM,  LEN3, CYC2};
      else if (op[7:1] == OPC_CMP_IND[7:1])   d = '{C_CMP,    M_IND,  LEN3, CYC2};
      else if (op[7:3] == OPC_CMP_REG[7:3])   d = '{C_CMP,    M_REG,  LEN3, CYC2};
      else if (op == OPC_CLR_A)               d = '{C_CLR_A,  M_NONE, LEN1, CYC1};
      else if (op == OPC_CLR_C)               d = '{C_CLR_C,  M_NONE, LEN1, CYC1};
      else if (op == OPC_CLR_BIT)             d = '{C_CLR_B,  M_BIT,  LEN2, CYC1};
      else if (op == OPC_INV_A)               d = '{C_INV_A,  M_NONE, LEN1, CYC1};
      else if (op == OPC_INV_C)               d = '{C_INV_C,  M_NONE, LEN1, CYC1};
      else if (op == OPC_INV_BIT)             d = '{C_INV_B,  M_BIT,  LEN2, CYC1};
      else if (op == OPC_DEC_ADJ)             d = '{C_DA,     M_NONE, LEN1, CYC1};
      return d;
   endfunction : lcb_decode

endpackage : lcb_pkg

// ### lcb_bcd_adjust.sv
// decimal adjust datapath: two-step bcd correction of the accumulator
`timescale 1ns/10ps
module lcb_bcd_adjust
   import lcb_pkg::*;
(
   input  wire logic [7:0] acc_i,      // accumulator before adjust
   input  wire logic       carry_i,    // carry flag before adjust
   input  wire logic       aux_i,      // aux_carry_flag
   output logic      [7:0] acc_o,      // adjusted accumulator
   output logic            carry_o     // carry after adjust
);

   logic       lo_fix;
   logic [8:0] step1;
   logic       carry1;
   logic       hi_fix;
   logic [4:0] step2;

   // low digit then high digit; carry is only ever set here, never cleared
   always_comb begin
      lo_fix  = (acc_i[3:0] > BCD_MAX) | aux_i;
      step1   = {1'h0, acc_i} + {5'h00, (lo_fix ? BCD_FIX : 4'h0)};
      carry1  = carry_i | step1[8];
      hi_fix  = carry1 | (step1[7:4] > BCD_MAX);
      step2   = {1'h0, step1[7:4]} + {1'h0, (hi_fix ? BCD_FIX : 4'h0)};
      carry_o = carry1 | step2[4];
      acc_o   = {step2[3:0], step1[3:0]};
   end

endmodule : lcb_bcd_adjust

// ### lcb_exec.sv
// executor for byte/bit and, compare-branch, clear, invert and decimal adjust instructions
`timescale 1ns/10ps
module lcb_exec
   import lcb_pkg::*;
(
   input  wire logic        clk_sys_i,     // system clock, 50 MHz
   input  wire logic        rst_i,         // synchronous reset, active high
   output logic      [15:0] prog_addr_o,   // program memory address
   input  wire logic [7:0]  prog_data_i,   // program byte at prog_addr_o, same cycle
   output logic      [7:0]  data_addr_o,   // data space address
   output logic             data_rd_o,     // data read strobe
   output logic             data_latch_o,  // read port output latch, not pins
   input  wire logic [7:0]  data_rdata_i,  // data at data_addr_o, same cycle
   output logic             data_wr_o,     // data write pulse
   output logic      [7:0]  data_wdata_o,  // data write value
   output logic      [7:0]  acc_o,         // accumulator_register
   output logic      [7:0]  psw_o,         // program_status_word with parity
   output logic             instr_done_o,  // pulse at end of each instruction
   output logic             illegal_op_o   // pulse for an opcode outside this group
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      lcb_state_t  st;
      logic [7:0]  op;
      logic [7:0]  b2;
      logic [7:0]  b3;
      logic [7:0]  opnd;
      logic [15:0] pc;
      logic [7:0]  acc;
      logic [7:0]  program_status_word;
      logic [2:0]  div;
      logic        mcyc;
      logic [7:0]  daddr;
      logic        drd;
      logic        dlatch;
      logic        dwr;
      logic [7:0]  dwdata;
      logic        done;
      logic        illegal;
   } lcb_state_s_t;

   lcb_state_s_t s_q;
   lcb_state_s_t s_d;

   lcb_dec_t     dec;
   logic [7:0]   reg_addr;
   logic [7:0]   ptr_addr;
   logic [7:0]   bit_byte;
   logic [7:0]   bit_mask;
   logic         bit_val;
   logic         dir_space;
   logic [7:0]   rd_val;
   logic [7:0]   cmp_a;
   logic [7:0]   cmp_b;
   logic [7:0]   wbyte;
   logic         wen;
   logic [7:0]   da_acc;
   logic         da_carry;

   ////////////////////////////////////////////////////////////////////////////
   // decimal adjust datapath
   lcb_bcd_adjust u_bcd (
      .acc_i   (s_q.acc),
      .carry_i (s_q.program_status_word[PSW_CY]),
      .aux_i   (s_q.program_status_word[PSW_AC]),
      .acc_o   (da_acc),
      .carry_o (da_carry)
   );

   ////////////////////////////////////////////////////////////////////////////
   // address formation and operand selection
   always_comb begin
      dec       = lcb_decode(s_q.op);
      reg_addr  = {3'h0, s_q.program_status_word[PSW_RS1], s_q.program_status_word[PSW_RS0], s_q.op[2:0]};
      ptr_addr  = {3'h0, s_q.program_status_word[PSW_RS1], s_q.program_status_word[PSW_RS0], 2'h0, s_q.op[0]};
      // low bit addresses map into the bit ram, high ones onto bit-addressable sfrs
      bit_byte  = s_q.b2[7] ? {s_q.b2[7:3], 3'h0} : {BIT_RAM_BASE, s_q.b2[6:3]};
      bit_mask  = 8'h01 << s_q.b2[2:0];
      bit_val   = s_q.opnd[s_q.b2[2:0]];
      dir_space = (dec.src == M_DIR) || (dec.src == M_BIT);
      // accumulator and status word live here, not on the data port
      if (dir_space && s_q.daddr == ACC_ADDR) begin
         rd_val = s_q.acc;
      end else if (dir_space && s_q.daddr == PSW_ADDR) begin
         rd_val = s_q.program_status_word;
      end else begin
         rd_val = data_rdata_i;
      end
      // compare pairings: accumulator against direct or data, else operand against data
      if (dec.src == M_DIR) begin
         cmp_a = s_q.acc;
         cmp_b = s_q.opnd;
      end else if (dec.src == M_IMM) begin
         cmp_a = s_q.acc;
         cmp_b = s_q.b2;
      end else begin
         cmp_a = s_q.opnd;
         cmp_b = s_q.b2;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer and execution
   always_comb begin
      s_d         = s_q;
      wbyte       = s_q.opnd;
      wen         = 1'h0;
      s_d.done    = 1'h0;
      s_d.illegal = 1'h0;
      s_d.dwr     = 1'h0;
      s_d.div     = (s_q.div == MC_LAST) ? 3'h0 : s_q.div + 3'h1;

      case (s_q.st)
         // opcode byte, always at the start of a machine cycle
         S_OP: begin
            s_d.op   = prog_data_i;
            s_d.pc   = s_q.pc + 16'h0001;
            s_d.mcyc = 1'h0;
            s_d.st   = S_B2;
         end
         // second byte: direct or bit address, or data when none is needed
         S_B2: begin
            if (dec.len >= LEN2) begin
               s_d.b2 = prog_data_i;
               s_d.pc = s_q.pc + 16'h0001;
            end
            if (dec.src == M_REG) begin
               s_d.daddr = reg_addr;
               s_d.drd   = 1'h1;
            end else if (dec.src == M_IND) begin
               s_d.daddr = ptr_addr;
               s_d.drd   = 1'h1;
            end
            s_d.st = S_B3;
         end
         // third byte: data after an address, displacement always last
         S_B3: begin
            if (dec.len == LEN3) begin
               s_d.b3 = prog_data_i;
               s_d.pc = s_q.pc + 16'h0001;
            end
            if (dec.src == M_DIR || dec.src == M_BIT) begin
               s_d.daddr = (dec.src == M_BIT) ? bit_byte : s_q.b2;
               s_d.drd   = 1'h1;
               // read-modify-write on a port takes the output latch
               s_d.dlatch = (dec.cls == C_AND_DA) || (dec.cls == C_AND_DI)
                         || (dec.cls == C_CLR_B) || (dec.cls == C_INV_B);
            end
            s_d.st = S_RDP;
         end
         // indirect: pointer register value becomes the address
         S_RDP: begin
            if (dec.src == M_IND) begin
               s_d.daddr = data_rdata_i;
            end
            s_d.st = S_RDO;
         end
         // operand capture
         S_RDO: begin
            s_d.opnd   = rd_val;
            s_d.drd    = 1'h0;
            s_d.dlatch = 1'h0;
            s_d.st     = S_EXEC;
         end
         // execute
         S_EXEC: begin
            case (dec.cls)
               C_AND_A: begin
                  s_d.acc = s_q.acc & ((dec.src == M_IMM) ? s_q.b2 : s_q.opnd);
               end
               C_AND_DA: begin
                  wbyte = s_q.opnd & s_q.acc;
                  wen   = 1'h1;
               end
               C_AND_DI: begin
                  wbyte = s_q.opnd & s_q.b3;
                  wen   = 1'h1;
               end
               C_AND_C: begin
                  if (!bit_val) s_d.program_status_word[PSW_CY] = 1'h0;
               end
               C_AND_NC: begin
                  if (bit_val) s_d.program_status_word[PSW_CY] = 1'h0;
               end
               C_CMP: begin
                  s_d.program_status_word[PSW_CY] = (cmp_a < cmp_b);
                  if (cmp_a != cmp_b) begin
                     s_d.pc = s_q.pc + {{8{s_q.b3[7]}}, s_q.b3};
                  end
               end
               C_CLR_A: begin
                  s_d.acc = 8'h00;
               end
               C_CLR_C: begin
                  s_d.program_status_word[PSW_CY] = 1'h0;
               end
               C_CLR_B: begin
                  wbyte = s_q.opnd & ~bit_mask;
                  wen   = 1'h1;
               end
               C_INV_A: begin
                  s_d.acc = ~s_q.acc;
               end
               C_INV_C: begin
                  s_d.program_status_word[PSW_CY] = ~s_q.program_status_word[PSW_CY];
               end
               C_INV_B: begin
                  wbyte = s_q.opnd ^ bit_mask;
                  wen   = 1'h1;
               end
               C_DA: begin
                  s_d.acc         = da_acc;
                  s_d.program_status_word[PSW_CY] = da_carry;
               end
               default: begin
                  s_d.illegal = 1'h1;
               end
            endcase
            // write back: internal registers locally, everything else on the port
            if (wen && s_q.daddr == ACC_ADDR) begin
               s_d.acc = wbyte;
            end else if (wen && s_q.daddr == PSW_ADDR) begin
               s_d.program_status_word = wbyte;
            end else if (wen) begin
               s_d.dwr    = 1'h1;
               s_d.dwdata = wbyte;
            end
            s_d.st = S_WAIT;
         end
         // hold until the instruction's machine cycles have elapsed
         S_WAIT: begin
            if (s_q.div == MC_LAST) begin
               if (s_q.mcyc == dec.cyc) begin
                  s_d.st   = S_OP;
                  s_d.done = 1'h1;
               end else begin
                  s_d.mcyc = 1'h1;
               end
            end
         end
         default: begin
            s_d.st = S_OP;
         end
      endcase

      s_d.program_status_word[PSW_PAR] = ^s_d.acc;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from state
   assign prog_addr_o  = s_q.pc;
   assign data_addr_o  = s_q.daddr;
   assign data_rd_o    = s_q.drd;
   assign data_latch_o = s_q.dlatch;
   assign data_wr_o    = s_q.dwr;
   assign data_wdata_o = s_q.dwdata;
   assign acc_o        = s_q.acc;
   assign psw_o        = s_q.program_status_word;
   assign instr_done_o = s_q.done;
   assign illegal_op_o = s_q.illegal;

endmodule : lcb_exec

// ### lcb_exec_sva.sv
// checker for the executor ports
`timescale 1ns/10ps
module lcb_exec_sva
   import lcb_pkg::*;
(
   input wire logic        clk_sys_i,    // clock
   input wire logic        rst_i,        // reset
   input wire logic [15:0] prog_addr_o,  // pc
   input wire logic [7:0]  prog_data_i,  // code byte
   input wire logic [7:0]  data_addr_o,  // address
   input wire logic        data_rd_o,    // read
   input wire logic        data_latch_o, // latch read
   input wire logic [7:0]  data_rdata_i, // read data
   input wire logic        data_wr_o,    // write
   input wire logic [7:0]  data_wdata_o, // write data
   input wire logic [7:0]  acc_o,        // acc
   input wire logic [7:0]  psw_o,        // status
   input wire logic        instr_done_o, // done
   input wire logic        illegal_op_o  // illegal
);
   logic       first_q;
   logic [7:0] op_q;
   logic       st, op1c, op2c;
   // opcode cycle tracking
   always_ff @(posedge clk_sys_i) begin
      first_q <= rst_i;
      if (st) op_q <= prog_data_i;
   end
   assign st   = first_q | instr_done_o;
   assign op1c = st && (prog_data_i inside {8'h52, [8'h54:8'h5F], 8'hB2, 8'hB3, 8'hC2, 8'hC3, 8'hD4, 8'hE4, 8'hF4});
   assign op2c = st && (prog_data_i inside {8'h53, 8'h82, 8'hB0, [8'hB4:8'hBF]});
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   a_done_gap: assert property (instr_done_o |=> !instr_done_o[*7])
      else $error("done pulses too close");
   a_parity_acc: assert property (psw_o[0] == ^acc_o)
      else $error("parity off");
   a_clr_acc: assert property (instr_done_o && op_q == OPC_CLR_A |-> acc_o == 8'h00)
      else $error("acc not cleared");
   a_inv_acc: assert property (st && prog_data_i == OPC_INV_A |-> ##8 acc_o == ~$past(acc_o, 8) &&
      psw_o[7:1] == $past(psw_o[7:1], 8)) else $error("acc invert wrong");
   a_len_one: assert property (op1c |-> ##8 instr_done_o)
      else $error("one cycle op length");
   a_len_two: assert property (op2c |=> !instr_done_o[*8] ##8 instr_done_o)
      else $error("two cycle op length");
   a_inv_carry: assert property (st && prog_data_i == OPC_INV_C |-> ##8 psw_o[7] != $past(psw_o[7], 8))
      else $error("carry not inverted");
   a_latch_read: assert property (data_latch_o |-> data_rd_o)
      else $error("latch read without read");
   a_illegal_op: assert property (illegal_op_o |-> $past(st && !(op1c || op2c), 6) ##2 instr_done_o) // outside group
      else $error("illegal pulse misplaced");
   c_write: cover property (data_wr_o);
   c_adjust: cover property (instr_done_o && op_q == OPC_DEC_ADJ);
   c_illegal: cover property (illegal_op_o);
endmodule : lcb_exec_sva
bind lcb_exec lcb_exec_sva u_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .prog_addr_o(prog_addr_o),
   .prog_data_i(prog_data_i), .data_addr_o(data_addr_o), .data_rd_o(data_rd_o), .data_latch_o(data_latch_o),
   .data_rdata_i(data_rdata_i), .data_wr_o(data_wr_o), .data_wdata_o(data_wdata_o), .acc_o(acc_o),
   .psw_o(psw_o), .instr_done_o(instr_done_o), .illegal_op_o(illegal_op_o));

// ### lcb_data_mem.sv
// data space model: ram, sfr latches and port pins
`timescale 1ns/10ps
module lcb_data_mem
   import lcb_pkg::*;
(
   input  wire logic       clk_sys_i, // clock
   input  wire logic [7:0] addr_i,    // address
   input  wire logic       rd_i,      // read
   input  wire logic       latch_i,   // latch read
   input  wire logic       wr_i,      // write
   input  wire logic [7:0] wdata_i,   // write data
   output logic      [7:0] rdata_o    // read data
);
   logic [7:0] mem [0:255];
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
      rdata_o = 8'h00;
   end
   // port 90h pins read as inverse of latch; idle bus keeps toggling
   always @(negedge clk_sys_i) begin
      if (rd_i) rdata_o <= (addr_i == 8'h90 && !latch_i) ? ~mem[addr_i] : mem[addr_i];
      else rdata_o <= ~rdata_o;
   end
   // write pulse stores
   always @(posedge clk_sys_i) begin
      if (wr_i) mem[addr_i] <= wdata_i;
   end
endmodule : lcb_data_mem

// ### tb_logic_compare_bcd_ops.sv
// self-checking bench for the executor
`timescale 1ns/10ps
module tb_logic_compare_bcd_ops;
   import lcb_pkg::*;
   typedef struct packed {
      logic        k;
      logic [15:0] x;
      logic [7:0]  y;
      logic [7:0]  z;
   } lcb_note_t;
   logic        clk_sys_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  prog_data_i = 8'h00;
   logic [15:0] prog_addr_o, pc;
   logic [7:0]  data_addr_o, data_rdata_i, data_wdata_o, acc_o, psw_o, a, p, rv;
   logic        data_rd_o, data_latch_o, data_wr_o, instr_done_o, illegal_op_o;
   int          n_mismatch = 0;
   int          check_count = 0;
   logic [7:0]  prog [0:65535];
   logic [7:0]  dm [0:255];
   logic [31:0] seed = 32'h0001526A;
   lcb_note_t   q [$];
   lcb_exec dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i),
      .data_addr_o(data_addr_o), .data_rd_o(data_rd_o), .data_latch_o(data_latch_o), .data_rdata_i(data_rdata_i),
      .data_wr_o(data_wr_o), .data_wdata_o(data_wdata_o), .acc_o(acc_o), .psw_o(psw_o),
      .instr_done_o(instr_done_o), .illegal_op_o(illegal_op_o));
   lcb_data_mem u_mem (.clk_sys_i(clk_sys_i), .addr_i(data_addr_o), .rd_i(data_rd_o), .latch_i(data_latch_o),
      .wr_i(data_wr_o), .wdata_i(data_wdata_o), .rdata_o(data_rdata_i));
   initial begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   // code bytes follow the pc
   always @(negedge clk_sys_i) prog_data_i <= prog[prog_addr_o];
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd
   function automatic logic [7:0] rd(input logic [7:0] ad, input logic lt);
      if (ad == ACC_ADDR) return a;
      if (ad == PSW_ADDR) return p;
      return (ad == 8'h90 && !lt) ? ~dm[ad] : dm[ad];
   endfunction : rd
   task automatic wr(input logic [7:0] ad, input logic [7:0] v);
      if (ad == ACC_ADDR) a = v;
      else if (ad == PSW_ADDR) p = v;
      else begin
         dm[ad] = v;
         q.push_back('{1'b1, {8'h00, ad}, v, 8'h00});
      end
   endtask : wr
   // reference model: place one instruction and note its outcome
   task automatic ins(input logic [7:0] o, input logic [7:0] b1, input logic [7:0] b2);
      logic [7:0] r, x, y, ba, s;
      logic [8:0] w;
      int         n;
      logic       br;
      r  = o[3] ? rd({3'h0, p[4:3], o[2:0]}, 1'b0) : rd(rd({3'h0, p[4:3], 2'h0, o[0]}, 1'b0), 1'b0);
      ba = b1[7] ? {b1[7:3], 3'h0} : {4'h2, b1[6:3]};
      s  = rd(ba, o inside {8'hB2, 8'hC2});
      x  = (o == 8'hB5) ? rd(b1, 1'b0) : b1;
      y  = (o inside {8'hB4, 8'hB5}) ? a : r;
      br = 1'b0;
      w  = {1'b0, a};
      case (o) inside
         [8'h56:8'h5F]: a = a & r;
         8'h54:         a = a & b1;
         8'h55:         a = a & rd(b1, 1'b0);
         8'h52:         wr(b1, rd(b1, 1'b1) & a);
         8'h53:         wr(b1, rd(b1, 1'b1) & b2);
         8'h82:         if (!s[b1[2:0]]) p[7] = 1'b0;
         8'hB0:         if (s[b1[2:0]]) p[7] = 1'b0;
         [8'hB4:8'hBF]: begin
            p[7] = y < x;
            br   = y != x;
         end
         8'hE4:         a = 8'h00;
         8'hC3:         p[7] = 1'b0;
         8'hB3:         p[7] = ~p[7];
         8'hF4:         a = ~a;
         8'hC2, 8'hB2:  begin
            s[b1[2:0]] = o[4] & ~s[b1[2:0]]; // clear for c2h, invert for b2h
            wr(ba, s);
         end
         8'hD4:         begin
            if (a[3:0] > 4'h9 || p[6]) w = w + 9'h006;
            p[7] = p[7] | w[8];
            if (w[7:4] > 4'h9 || p[7]) w = {1'b0, w[7:0]} + 9'h060;
            p[7] = p[7] | w[8];
            a = w[7:0];
         end
         default: ;
      endcase
      n = (o == 8'h53 || o inside {[8'hB4:8'hBF]}) ? 3 : (o inside {8'h52, 8'h54, 8'h55, 8'h82, 8'hB0, 8'hB2, 8'hC2}) ? 2 : 1;
      p[0] = ^a;
      prog[pc] = o;
      prog[pc + 16'h0001] = b1;
      prog[pc + 16'h0002] = b2;
      pc = pc + 16'(n) + (br ? {{8{b2[7]}}, b2} : 16'h0000);
      q.push_back('{1'b0, pc, a, p});
   endtask : ins
   task automatic cmp(input lcb_note_t g);
      lcb_note_t e;
      e = (q.size() > 0) ? q.pop_front() : '1;
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   task automatic report_and_stop();
      if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////
   // result watcher
   always @(negedge clk_sys_i) begin
      if (data_wr_o === 1'b1) cmp('{1'b1, {8'h00, data_addr_o}, data_wdata_o, 8'h00});
      if (instr_done_o === 1'b1) cmp('{1'b0, prog_addr_o, acc_o, psw_o});
   end
   initial begin
      #100000;
      n_mismatch++;
      report_and_stop();
   end
   // build program, release reset, wait for all notes
   initial begin
      for (int i = 0; i < 256; i++) dm[i] = 8'(i) ^ 8'h5A;
      for (int i = 0; i < 65536; i++) prog[i] = 8'h00;
      a = 8'h00;
      p = 8'h00;
      pc = 16'h0000;
      ins(8'hF4, 8'h00, 8'h00);
      ins(8'hB3, 8'h00, 8'h00);
      ins(8'hB2, 8'hD6, 8'h00);
      ins(8'hD4, 8'h00, 8'h00);
      repeat (6) begin
         ins(8'hE4, 8'h00, 8'h00);
         ins(8'hF4, 8'h00, 8'h00);
         ins(8'h54, rnd(), 8'h00);
         rv = rnd();
         ins(rv[0] ? 8'hB3 : 8'hC3, 8'h00, 8'h00);
         ins(rv[1] ? 8'hB2 : 8'hC2, 8'hD6, 8'h00);
         ins(8'hD4, 8'h00, 8'h00);
      end
      for (int i = 0; i < 10; i++) begin
         ins(8'hE4, 8'h00, 8'h00);
         ins(8'hF4, 8'h00, 8'h00);
         ins(8'h56 + 8'(i), 8'h00, 8'h00);
      end
      ins(8'h55, 8'h90, 8'h00);
      ins(8'h52, 8'h30, 8'h00);
      ins(8'h53, 8'h90, rnd());
      ins(8'hB2, 8'h91, 8'h00);
      repeat (8) begin
         rv = rnd();
         ins(8'hB3, 8'h00, 8'h00);
         ins(rv[0] ? 8'h82 : 8'hB0, rnd(), 8'h00);
         ins(8'hC2, rnd(), 8'h00);
      end
      for (int i = 0; i < 12; i++) begin
         rv = rnd();
         ins(8'hB4 + 8'(i), (i == 0) ? a : rnd(), {5'h00, rv[2:0]});
      end
      ins(8'h00, 8'h00, 8'h00);
      ins(8'hC3, 8'h00, 8'h00);
      repeat (2) @(negedge clk_sys_i);
      rst_i = 1'b0;
      while (q.size() > 0) @(negedge clk_sys_i);
      report_and_stop();
   end
endmodule : tb_logic_compare_bcd_ops
